// ### rtl/ufc_core.sv
// Purpose: Full-duplex asynchronous serial transceiver with 4-entry queues.
// Assumes: All inputs synchronous to CORE_CLK_I; control bits arrive as ports.
// Notes:   Buffer-to-shifter moves take one clock; interrupts are one-cycle pulses.
`timescale 1ns/1ps
`default_nettype none
module ufc_core
  import ufc_pkg::*;
(
  // Clock and reset
  input  wire logic        CORE_CLK_I,
  input  wire logic        RST_N_I,
  // Configuration
  input  wire logic        MODULE_ON_I,
  input  wire logic        ALT_PIN_SELECT_I,
  input  wire logic [1:0]  FORMAT_SELECT_I,
  input  wire logic        STOP_COUNT_SELECT_I,
  input  wire logic [15:0] BAUD_DIVISOR_I,
  input  wire logic        TX_IRQ_SELECT_I,
  input  wire logic [1:0]  RX_IRQ_SELECT_I,
  // Control strobes
  input  wire logic        TX_ENABLE_SET_I,
  input  wire logic        TX_ENABLE_CLR_I,
  input  wire logic        SEND_BREAK_SET_I,
  input  wire logic        SEND_BREAK_CLR_I,
  input  wire logic        OVERRUN_CLR_I,
  // Data access
  input  wire logic        TX_WRITE_I,
  input  wire logic [8:0]  TX_DATA_I,
  input  wire logic        RX_READ_I,
  output logic [8:0]       RX_DATA_O,
  // Serial pins
  input  wire logic        SERIAL_IN_PIN_I,
  input  wire logic        ALT_SERIAL_IN_PIN_I,
  output logic             SERIAL_OUT_PIN_O,
  output logic             SERIAL_OUT_OE_O,
  output logic             ALT_SERIAL_OUT_PIN_O,
  output logic             ALT_SERIAL_OUT_OE_O,
  // Status
  output logic             TX_ENABLE_O,
  output logic             SEND_BREAK_O,
  output logic             TX_FULL_FLAG_O,
  output logic             TX_SHIFTER_EMPTY_O,
  output logic             RX_AVAIL_FLAG_O,
  output logic             RX_IDLE_FLAG_O,
  output logic             OVERRUN_FLAG_O,
  output logic             FRAMING_ERR_FLAG_O,
  output logic             PARITY_ERR_FLAG_O,
  // Interrupt pulses
  output logic             TX_IRQ_FLAG_O,
  output logic             RX_IRQ_FLAG_O
);
  typedef struct packed {
    logic [3:0][8:0]  txq;         // Transmit queue storage
    logic [1:0]       txwr;
    logic [1:0]       txrd;
    logic [2:0]       txcnt;
    ufc_tx_st_t       ts;
    logic [8:0]       tsr;         // Transmit shifter
    logic             tpar;
    logic             tload;       // Shifter holds a character
    logic [3:0]       tsub;
    logic [3:0]       tbit;
    logic [3:0][10:0] rxq;         // {parity err, framing err, data}
    logic [1:0]       rxwr;
    logic [1:0]       rxrd;
    logic [2:0]       rxcnt;
    ufc_rx_st_t       rs;
    logic [8:0]       rsr;         // Receive shifter
    logic             rpar;
    logic             rferr;
    logic [3:0]       rsub;
    logic [3:0]       rbit;
    logic [8:0]       rxdata;
    logic             parity_err_flag;
    logic             framing_err_flag;
    logic             overrun_flag;
    logic             rxidle;
    logic             txen;
    logic             brk;
    logic             tsre;
    logic             txirq;
    logic             rxirq;
    logic             pout;
    logic             poe;
    logic             aout;
    logic             aoe;
  } ufc_state_t;

  ufc_state_t r_reg;
  ufc_state_t r_next;
  logic       tick;
  logic       line;
  logic       tx_pop;
  logic       tx_push;
  logic       rx_pop;
  logic       rx_push;
  logic       txd;
  logic       nine;
  logic       has_par;
  logic [8:0] rword;

  // ==========================================================
  // Baud tick: counter restarts whenever the core is off
  ufc_baud_gen u_baud (
    .CORE_CLK_I (CORE_CLK_I),
    .RST_N_I    (RST_N_I),
    .clear_i    (!MODULE_ON_I),
    .divisor_i  (BAUD_DIVISOR_I),
    .tick_o     (tick)
  );

  // ==========================================================
  // Next-state logic
  always_comb begin
    r_next       = r_reg;
    r_next.txirq = 1'b0;
    r_next.rxirq = 1'b0;
    nine         = (FORMAT_SELECT_I == FMT_9N);
    has_par      = (FORMAT_SELECT_I == FMT_8E) || (FORMAT_SELECT_I == FMT_8O);
    line         = ALT_PIN_SELECT_I ? ALT_SERIAL_IN_PIN_I : SERIAL_IN_PIN_I;
    tx_push      = 1'b0;
    tx_pop       = 1'b0;
    rx_push      = 1'b0;
    rx_pop       = 1'b0;
    txd          = 1'b1;
    rword        = nine ? r_reg.rsr : {1'b0, r_reg.rsr[8:1]};
    if (!MODULE_ON_I) begin
      // Off: abort, empty queues, clear flags; configuration ports untouched
      r_next.txwr   = 2'h0;
      r_next.txrd   = 2'h0;
      r_next.txcnt  = 3'h0;
      r_next.rxwr   = 2'h0;
      r_next.rxrd   = 2'h0;
      r_next.rxcnt  = 3'h0;
      r_next.ts     = TX_IDLE;
      r_next.rs     = RX_IDLE;
      r_next.tload  = 1'b0;
      r_next.tsub   = 4'h0;
      r_next.rsub   = 4'h0;
      r_next.parity_err_flag   = 1'b0;
      r_next.framing_err_flag   = 1'b0;
      r_next.overrun_flag   = 1'b0;
      r_next.txen   = 1'b0;
      r_next.brk    = 1'b0;
      r_next.rxidle = 1'b1;
    end else begin
      // Software strobes; clear has no priority over a same-cycle set
      if (TX_ENABLE_SET_I) r_next.txen = 1'b1;
      else if (TX_ENABLE_CLR_I) r_next.txen = 1'b0;
      if (SEND_BREAK_SET_I) r_next.brk = 1'b1;
      else if (SEND_BREAK_CLR_I) r_next.brk = 1'b0;
      if (OVERRUN_CLR_I) r_next.overrun_flag = 1'b0;

      // Transmit queue: writes to a full queue are dropped
      tx_push = TX_WRITE_I && (r_reg.txcnt != Q_FULL);
      tx_pop  = r_reg.txen && !r_reg.tload && (r_reg.txcnt != 3'h0);
      if (tx_push) begin
        r_next.txq[r_reg.txwr] = TX_DATA_I;
        r_next.txwr            = r_reg.txwr + 2'h1;
      end
      if (tx_pop) begin
        r_next.tsr   = r_reg.txq[r_reg.txrd];
        r_next.tpar  = (^r_reg.txq[r_reg.txrd][7:0]) ^ (FORMAT_SELECT_I == FMT_8O);
        r_next.tload = 1'b1;
        r_next.txrd  = r_reg.txrd + 2'h1;
        r_next.tsub  = 4'h0;
        // Select sampled live so software may switch it at run time
        r_next.txirq = !TX_IRQ_SELECT_I || (r_reg.txcnt == 3'h1);
      end
      r_next.txcnt = r_reg.txcnt + {2'h0, tx_push} - {2'h0, tx_pop};

      // Transmit shifter, one step per baud tick
      if (tick) begin
        r_next.tsub = r_reg.tsub + 4'h1;
        unique case (r_reg.ts)
          TX_IDLE: begin
            r_next.tsub = 4'h0;
            if (r_reg.tload) r_next.ts = TX_START;
          end
          TX_START: begin
            if (r_reg.tsub == SUB_LAST) begin
              r_next.ts   = TX_DATA;
              r_next.tbit = 4'h0;
            end
          end
          TX_DATA: begin
            if (r_reg.tsub == SUB_LAST) begin
              r_next.tsr  = {1'b0, r_reg.tsr[8:1]};
              r_next.tbit = r_reg.tbit + 4'h1;
              if (r_reg.tbit == (nine ? DATA_LAST9 : DATA_LAST8)) begin
                r_next.ts   = has_par ? TX_PAR : TX_STOP;
                r_next.tbit = 4'h0;
              end
            end
          end
          TX_PAR: begin
            if (r_reg.tsub == SUB_LAST) r_next.ts = TX_STOP;
          end
          TX_STOP: begin
            if (r_reg.tsub == SUB_LAST) begin
              r_next.tbit = r_reg.tbit + 4'h1;
              if (r_reg.tbit == {3'h0, STOP_COUNT_SELECT_I}) begin
                r_next.ts    = TX_IDLE;
                r_next.tload = 1'b0;
              end
            end
          end
        endcase
      end

      // Receive queue pop; an empty read leaves everything in place
      rx_pop = RX_READ_I && (r_reg.rxcnt != 3'h0);
      if (rx_pop) r_next.rxrd = r_reg.rxrd + 2'h1;

      // Receive shifter: bit steps on the sixteen-times tick; start edge and wait-for-high checked every clock
      unique case (r_reg.rs)
        RX_IDLE: begin
          if (!r_reg.overrun_flag && !line) begin
            r_next.rs     = RX_START;
            r_next.rsub   = 4'h0;
            r_next.rxidle = 1'b0;
          end
        end
        RX_START: begin
          if (tick) begin
            r_next.rsub = r_reg.rsub + 4'h1;
            if (r_reg.rsub == SUB_MID) begin
              // A glitch shorter than half a bit is not a start
              r_next.rs     = line ? RX_IDLE : RX_DATA;
              r_next.rxidle = line;
              r_next.rsub   = 4'h0;
              r_next.rbit   = 4'h0;
              r_next.rpar   = 1'b0;
              r_next.rferr  = 1'b0;
            end
          end
        end
        RX_DATA: begin
          if (tick) begin
            r_next.rsub = r_reg.rsub + 4'h1;
            if (r_reg.rsub == SUB_LAST) begin
              r_next.rsr  = {line, r_reg.rsr[8:1]};
              r_next.rpar = r_reg.rpar ^ line;
              r_next.rbit = r_reg.rbit + 4'h1;
              if (r_reg.rbit == (nine ? DATA_LAST9 : DATA_LAST8)) begin
                r_next.rs   = has_par ? RX_PAR : RX_STOP;
                r_next.rbit = 4'h0;
              end
            end
          end
        end
        RX_PAR: begin
          if (tick) begin
            r_next.rsub = r_reg.rsub + 4'h1;
            if (r_reg.rsub == SUB_LAST) begin
              r_next.rpar = r_reg.rpar ^ line ^ (FORMAT_SELECT_I == FMT_8O);
              r_next.rs   = RX_STOP;
            end
          end
        end
        RX_STOP: begin
          if (tick) begin
            r_next.rsub = r_reg.rsub + 4'h1;
            if (r_reg.rsub == SUB_LAST) begin
              r_next.rferr = r_reg.rferr | !line;
              r_next.rbit  = r_reg.rbit + 4'h1;
              if (r_reg.rbit == {3'h0, STOP_COUNT_SELECT_I}) begin
                if (r_reg.rxcnt == Q_FULL && !rx_pop) begin
                  r_next.overrun_flag = 1'b1;
                end else begin
                  rx_push = 1'b1;
                  r_next.rxq[r_reg.rxwr] = {has_par & r_reg.rpar, r_reg.rferr | !line, rword};
                  r_next.rxwr = r_reg.rxwr + 2'h1;
                end
                // A break keeps the line low: wait for it to rise first
                r_next.rs     = (r_reg.rferr | !line) ? RX_WAIT : RX_IDLE;
                r_next.rxidle = 1'b1;
              end
            end
          end
        end
        RX_WAIT: begin
          if (line) r_next.rs = RX_IDLE;
        end
      endcase
      r_next.rxcnt = r_reg.rxcnt + {2'h0, rx_push} - {2'h0, rx_pop};
      if (rx_push) begin
        unique case (RX_IRQ_SELECT_I)
          RXI_HIGH: r_next.rxirq = (r_next.rxcnt >= Q_HIGH);
          RXI_FULL: r_next.rxirq = (r_next.rxcnt == Q_FULL);
          default:  r_next.rxirq = 1'b1;
        endcase
      end
      // Head of the receive queue is what software sees
      if (r_next.rxcnt != 3'h0 && (rx_pop || r_reg.rxcnt == 3'h0)) begin
        r_next.rxdata = r_next.rxq[r_next.rxrd][8:0];
        r_next.framing_err_flag   = r_next.rxq[r_next.rxrd][9];
        r_next.parity_err_flag   = r_next.rxq[r_next.rxrd][10];
      end
    end

    // Pin drive: break wins over every transmit state
    unique case (r_next.ts)
      TX_START: txd = 1'b0;
      TX_DATA:  txd = r_next.tsr[0];
      TX_PAR:   txd = r_next.tpar;
      default:  txd = 1'b1;
    endcase
    if (r_next.brk) txd = 1'b0;
    r_next.tsre = !r_next.tload;
    r_next.pout = txd;
    r_next.aout = txd;
    r_next.poe  = MODULE_ON_I && !ALT_PIN_SELECT_I;
    r_next.aoe  = MODULE_ON_I && ALT_PIN_SELECT_I;
  end

  // ==========================================================
  // State register; queues clear only on reset or disable
  always_ff @(posedge CORE_CLK_I) begin
    if (!RST_N_I) begin
      r_reg        <= '0;
      r_reg.ts     <= TX_IDLE;
      r_reg.rs     <= RX_IDLE;
      r_reg.rxidle <= 1'b1;
      r_reg.tsre   <= 1'b1;
      r_reg.pout   <= 1'b1;
      r_reg.aout   <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  // Outputs straight from the state register
  assign RX_DATA_O            = r_reg.rxdata;
  assign SERIAL_OUT_PIN_O     = r_reg.pout;
  assign SERIAL_OUT_OE_O      = r_reg.poe;
  assign ALT_SERIAL_OUT_PIN_O = r_reg.aout;
  assign ALT_SERIAL_OUT_OE_O  = r_reg.aoe;
  assign TX_ENABLE_O          = r_reg.txen;
  assign SEND_BREAK_O         = r_reg.brk;
  assign TX_FULL_FLAG_O       = (r_reg.txcnt == Q_FULL);
  assign TX_SHIFTER_EMPTY_O   = r_reg.tsre;
  assign RX_AVAIL_FLAG_O      = (r_reg.rxcnt != 3'h0);
  assign RX_IDLE_FLAG_O       = r_reg.rxidle;
  assign OVERRUN_FLAG_O       = r_reg.overrun_flag;
  assign FRAMING_ERR_FLAG_O   = r_reg.framing_err_flag;
  assign PARITY_ERR_FLAG_O    = r_reg.parity_err_flag;
  assign TX_IRQ_FLAG_O        = r_reg.txirq;
  assign RX_IRQ_FLAG_O        = r_reg.rxirq;

  // ==========================================================
  // Checks
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (!RST_N_I);

  break_low_a: assert property (r_reg.brk |-> !r_reg.pout && !r_reg.aout)
    else $error("break does not hold the line low");
  idle_high_a: assert property (!r_reg.brk && r_reg.ts == TX_IDLE |-> r_reg.pout)
    else $error("idle transmit line not high");
  disable_clear_a: assert property (!MODULE_ON_I |=> r_reg.txcnt == 3'h0 && r_reg.rxcnt == 3'h0
                                    && !r_reg.overrun_flag && r_reg.rxidle && r_reg.tsre && !r_reg.txen)
    else $error("disable left state behind");
  full_drop_a: assert property (r_reg.txcnt == Q_FULL && !r_reg.txen && MODULE_ON_I
                                |=> r_reg.txq == $past(r_reg.txq))
    else $error("full transmit queue altered");
  tx_sel_a: assert property (r_reg.txirq && $past(TX_IRQ_SELECT_I) |-> r_reg.txcnt == 3'h0 || $past(TX_WRITE_I))
    else $error("transmit pulse while queue not empty");
  rx_full_a: assert property (r_reg.rxirq && $past(RX_IRQ_SELECT_I) == RXI_FULL |-> r_reg.rxcnt == Q_FULL)
    else $error("full-select receive pulse early");
  empty_read_a: assert property (RX_READ_I && r_reg.rxcnt == 3'h0 && MODULE_ON_I && !rx_push
                                 |=> r_reg.rxdata == $past(r_reg.rxdata))
    else $error("empty read changed data");
  overrun_hold_a: assert property (r_reg.overrun_flag && !OVERRUN_CLR_I && MODULE_ON_I |=> r_reg.overrun_flag
                                   && (r_reg.rs == RX_IDLE || r_reg.rs == RX_WAIT))
    else $error("overrun dropped or receiver resumed");
  pin_own_a: assert property (r_reg.poe |-> !r_reg.aoe && $past(MODULE_ON_I) && !$past(ALT_PIN_SELECT_I))
    else $error("both pin pairs driven");
endmodule : ufc_core
`default_nettype wire

// ### rtl/ufc_pkg.sv
// Purpose: Shared constants and types for the serial transceiver core.
// Assumes: One 125 MHz clock, synchronous active-low reset.
// Notes:   Enumerations are one-hot; field positions are kept for software reference.
package ufc_pkg;
  // ==========================================================
  // Field positions of the software-visible mode and status words
  localparam int unsigned MODE_ALT_PIN_BIT = 10;     // Alternate pin pair select
  localparam int unsigned STAT_BREAK_BIT   = 11;     // Break request
  localparam int unsigned STAT_AVAIL_BIT   = 0;      // Receive data available

  // ==========================================================
  // Character format codes
  localparam logic [1:0] FMT_8N = 2'h0;              // 8 data, no parity (power-on)
  localparam logic [1:0] FMT_8E = 2'h1;              // 8 data, even parity
  localparam logic [1:0] FMT_8O = 2'h2;              // 8 data, odd parity
  localparam logic [1:0] FMT_9N = 2'h3;              // 9 data, no parity
  localparam logic       STOP_ONE = 1'h0;            // Power-on stop setting

  // Receive interrupt select codes
  localparam logic [1:0] RXI_HIGH = 2'h2;            // Three or four held
  localparam logic [1:0] RXI_FULL = 2'h3;            // Buffer full

  // ==========================================================
  // Buffer geometry and bit timing
  localparam int unsigned DATA_W    = 9;
  localparam logic [2:0]  Q_FULL    = 3'h4;          // Four entries per buffer
  localparam logic [2:0]  Q_HIGH    = 3'h3;
  localparam logic [3:0]  DATA_LAST8 = 4'h7;
  localparam logic [3:0]  DATA_LAST9 = 4'h8;
  localparam logic [3:0]  SUB_LAST  = 4'hf;          // Sixteen ticks per bit
  localparam logic [3:0]  SUB_MID   = 4'h7;          // Centre of start bit
  localparam int unsigned BREAK_MIN_BAUD = 13;       // Least break length software keeps

  // ==========================================================
  // State encodings
  typedef enum logic [4:0] {
    TX_IDLE  = 5'h01,
    TX_START = 5'h02,
    TX_DATA  = 5'h04,
    TX_PAR   = 5'h08,
    TX_STOP  = 5'h10
  } ufc_tx_st_t;

  typedef enum logic [5:0] {
    RX_IDLE  = 6'h01,
    RX_START = 6'h02,
    RX_DATA  = 6'h04,
    RX_PAR   = 6'h08,
    RX_STOP  = 6'h10,
    RX_WAIT  = 6'h20
  } ufc_rx_st_t;
endpackage : ufc_pkg

// ### rtl/ufc_baud_gen.sv
// Purpose: Sixteen-times baud tick from a 16-bit divisor.
// Assumes: Divisor is stable while the link runs.
// Notes:   Tick rate is clock/(divisor+1); a bit spans sixteen ticks.
`timescale 1ns/1ps
`default_nettype none
module ufc_baud_gen
  import ufc_pkg::*;
(
  // Clock and reset
  input  wire logic        CORE_CLK_I,
  input  wire logic        RST_N_I,
  // Control
  input  wire logic        clear_i,
  input  wire logic [15:0] divisor_i,
  // Tick
  output logic             tick_o
);
  typedef struct packed {
    logic [15:0] cnt;
    logic        tick;
  } ufc_bg_t;

  ufc_bg_t bg_reg;
  ufc_bg_t bg_next;

  // ==========================================================
  // Divider: cleared counter means the first tick is a full period away
  always_comb begin
    bg_next      = bg_reg;
    bg_next.tick = 1'b0;
    if (clear_i) begin
      bg_next.cnt = 16'h0000;
    end else if (bg_reg.cnt >= divisor_i) begin
      bg_next.cnt  = 16'h0000;
      bg_next.tick = 1'b1;
    end else begin
      bg_next.cnt = bg_reg.cnt + 16'h0001;
    end
  end

  // State register
  always_ff @(posedge CORE_CLK_I) begin
    if (!RST_N_I) begin
      bg_reg <= '0;
    end else begin
      bg_reg <= bg_next;
    end
  end

  assign tick_o = bg_reg.tick;
endmodule : ufc_baud_gen
`default_nettype wire

// ### verif/ufc_remote.sv
// Purpose: Far-end serial transceiver model, 8 data bits, no parity.
// Assumes: Bit time of BIT clocks; line idles high.
// Notes:   Reports {stop, data} so a low stop is visible.
`timescale 1ns/1ps
`default_nettype none
module ufc_remote #(
  parameter int BIT = 16
) (
  input  wire logic clk_i,
  input  wire logic line_i,
  output logic      line_o,
  output logic [8:0] got_o,
  output logic      got_v_o
);
  // ==========================================================
  // Receive: find the start edge, then sample each bit centre
  initial begin
    got_v_o = 1'b0;
    got_o = 9'h000;
    line_o = 1'b1;
    forever begin
      @(negedge line_i);
      repeat (BIT / 2) @(posedge clk_i);
      for (int i = 0; i < 9; i++) begin
        repeat (BIT) @(posedge clk_i);
        got_o[i] = line_i;
      end
      got_v_o = 1'b1;
      @(posedge clk_i);
      got_v_o = 1'b0;
    end
  end

  // ==========================================================
  // Send one frame; line idles high after, like a pulled-up link
  task automatic send(input logic [7:0] d);
    logic [9:0] f;
    f = {1'b1, d, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge clk_i);
      line_o = f[i];
      repeat (BIT - 1) @(posedge clk_i);
    end
  endtask : send
endmodule : ufc_remote
`default_nettype wire

// ### verif/ufc_core_bench.sv
// Purpose: Self-checking bench of the serial transceiver core.
// Assumes: Divisor 0, so one bit is sixteen clocks.
// Notes:   Serial results are matched against a queue of notes.
`timescale 1ns/1ps
`default_nettype none
module uart_fifo_core_bench
  import ufc_pkg::*;
;
  logic clk, rst_n, on, alt, stp, txis, bs, bc, ts, tc, oc, wr, rd;
  logic [1:0] fmt, rxis;
  logic [8:0] wd, rxd, got;
  logic so, soe, aso, asoe, txen, brk, txf, tse, rxa, ridl, ovr, fe, pe;
  logic txi, rxi, rl, gv;
  logic [8:0] exp[$];
  logic [7:0] rv[3];
  int err_count, samples_checked, nti, nri;

  // ==========================================================
  // Design and far end; both in pins see the far end's line
  ufc_core dut (.CORE_CLK_I(clk), .RST_N_I(rst_n), .MODULE_ON_I(on),
    .ALT_PIN_SELECT_I(alt), .FORMAT_SELECT_I(fmt), .STOP_COUNT_SELECT_I(stp),
    .BAUD_DIVISOR_I(16'h0000), .TX_IRQ_SELECT_I(txis), .RX_IRQ_SELECT_I(rxis),
    .TX_ENABLE_SET_I(ts), .TX_ENABLE_CLR_I(tc), .SEND_BREAK_SET_I(bs),
    .SEND_BREAK_CLR_I(bc), .OVERRUN_CLR_I(oc), .TX_WRITE_I(wr), .TX_DATA_I(wd),
    .RX_READ_I(rd), .RX_DATA_O(rxd), .SERIAL_IN_PIN_I(rl), .ALT_SERIAL_IN_PIN_I(rl),
    .SERIAL_OUT_PIN_O(so), .SERIAL_OUT_OE_O(soe), .ALT_SERIAL_OUT_PIN_O(aso),
    .ALT_SERIAL_OUT_OE_O(asoe), .TX_ENABLE_O(txen), .SEND_BREAK_O(brk),
    .TX_FULL_FLAG_O(txf), .TX_SHIFTER_EMPTY_O(tse), .RX_AVAIL_FLAG_O(rxa),
    .RX_IDLE_FLAG_O(ridl), .OVERRUN_FLAG_O(ovr), .FRAMING_ERR_FLAG_O(fe),
    .PARITY_ERR_FLAG_O(pe), .TX_IRQ_FLAG_O(txi), .RX_IRQ_FLAG_O(rxi));
  ufc_remote #(.BIT(16)) rem (.clk_i(clk), .line_i(alt ? aso : so), .line_o(rl),
    .got_o(got), .got_v_o(gv));

  task automatic chk(input logic c, input string m);
    samples_checked++;
    if (c !== 1'b1) begin
      err_count++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask : tick

  task automatic put(input logic [8:0] d);
    wr = 1'b1;
    wd = d;
    tick(1);
    wr = 1'b0;
    // Let one edge pass so back-to-back calls never retoggle the strobe at once
    tick(1);
  endtask : put

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict

  // ==========================================================
  // Clock, pulse counters, and the checker of serial results
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(negedge clk) begin
    if (txi === 1'b1) nti++;
    if (rxi === 1'b1) nri++;
  end
  always @(posedge gv) begin
    chk(exp.size() != 0 && got === exp[0], "serial frame");
    if (exp.size() != 0) void'(exp.pop_front());
  end
  initial begin
    #100us;
    err_count++;
    give_verdict();
  end

  // ==========================================================
  // Main sequence
  initial begin
    {rst_n, on, alt, stp, txis, bs, bc, ts, tc, oc, wr, rd} = '0;
    {fmt, rxis, wd} = '0;
    void'($urandom(23539));
    tick(5);
    rst_n = 1'b1;
    tick(1);
    chk(so === 1'b1 && soe === 1'b0 && tse === 1'b1 && ridl === 1'b1, "reset");
    on = 1'b1;
    tick(2);
    chk(soe === 1'b1 && asoe === 1'b0 && so === 1'b1, "pin own");
    $display("test reset done");
    ts = 1'b1;
    tick(1);
    ts = 1'b0;
    for (int i = 0; i < 3; i++) begin
      wd = 9'($urandom() & 8'hff);
      exp.push_back({1'b1, wd[7:0]});
      put(wd);
    end
    for (int k = 0; k < 3000 && exp.size() != 0; k++) tick(1);
    chk(nti == 3, "tx pulses");
    $display("test send done");
    alt = 1'b1;
    txis = 1'b1;
    tc = 1'b1;
    tick(1);
    tc = 1'b0;
    for (int i = 0; i < 5; i++) begin
      if (i < 4) exp.push_back({1'b1, 8'(8'h30 + i)});
      put(9'(8'h30 + i));
    end
    chk(txf === 1'b1 && asoe === 1'b1 && soe === 1'b0, "full alt");
    ts = 1'b1;
    tick(1);
    ts = 1'b0;
    for (int k = 0; k < 4000 && exp.size() != 0; k++) tick(1);
    tick(200);
    chk(exp.size() == 0 && nti == 4 && tse === 1'b1, "drop");
    $display("test fill done");
    alt = 1'b0;
    rxis = RXI_HIGH;
    for (int i = 0; i < 3; i++) begin
      rv[i] = 8'($urandom());
      rem.send(rv[i]);
    end
    tick(4);
    chk(nri == 1 && rxa === 1'b1, "rx pulse");
    for (int i = 0; i < 4; i++) begin
      chk(rxd[7:0] === rv[i < 3 ? i : 2], "rx data");
      rd = 1'b1;
      tick(1);
      rd = 1'b0;
      tick(1);
    end
    chk(rxa === 1'b0 && fe === 1'b0, "empty");
    $display("test receive done");
    exp.push_back(9'h000);
    bs = 1'b1;
    tick(1);
    bs = 1'b0;
    tick(2);
    chk(so === 1'b0, "break low");
    tick(13 * 16);
    bc = 1'b1;
    tick(1);
    bc = 1'b0;
    tick(40);
    chk(so === 1'b1 && nti == 4 && exp.size() == 0, "break");
    $display("test break done");
    // Five frames unread: four fill the queue, the fifth overruns
    rxis = RXI_FULL;
    for (int i = 0; i < 5; i++) rem.send(8'h5a);
    tick(4);
    chk(ovr === 1'b1 && rxa === 1'b1 && nri == 2, "overrun");
    oc = 1'b1;
    tick(1);
    oc = 1'b0;
    tick(1);
    chk(ovr === 1'b0, "overrun clear");
    on = 1'b0;
    tick(2);
    chk(rxa === 1'b0 && txen === 1'b0 && tse === 1'b1 && ridl === 1'b1, "off");
    chk(soe === 1'b0 && txf === 1'b0 && ovr === 1'b0, "off pins");
    $display("test disable done");
    give_verdict();
  end
endmodule : uart_fifo_core_bench
`default_nettype wire
